// ### tsbi_top.sv
// Transmit S1 byte inserter: software or serial-port source per frame.
// Assumes S1_SLOT_IN comes from core-clock frame logic; serial pin is async.
//
// Summary of operation
// - With source select set, every frame's S1 slot carries the software value.
// - An eight-bit read/write software S1 value register resets to zero.
// - With source select clear, the overhead enable bit lets the serial port supply overhead bytes.
// - With source select clear, each frame's S1 slot carries the next buffered port byte, or keeps the previous byte if none is buffered.
// - Each bit is latched on the port clock rise after the fall that launched it.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module tsbi_top #(
   parameter int unsigned FRAME_PERIODS = tsbi_pkg::FRAME_PERIODS_DEF,
   parameter int unsigned S1_WAIT       = tsbi_pkg::S1_WAIT_DEF,
   parameter int unsigned FIFO_DEPTH    = tsbi_pkg::FIFO_DEPTH_DEF
) (
   input  wire logic        CORE_CLK_IN,                    // 25 MHz core clock
   input  wire logic        RESETN_IN,                      // Async reset, low
   input  wire logic        WB_CYC_IN,                      // Wishbone cycle
   input  wire logic        WB_STB_IN,                      // Wishbone strobe
   input  wire logic        WB_WE_IN,                       // Write enable
   input  wire logic [15:0] WB_ADR_IN,                      // Byte address
   input  wire logic [3:0]  WB_SEL_IN,                      // Byte lanes
   input  wire logic [31:0] WB_DAT_IN,                      // Write data
   output logic      [31:0] WB_DAT_OUT,                     // Read data
   output logic             WB_ACK_OUT,                     // Acknowledge
   input  wire logic        OVERHEAD_SERIAL_IN,             // Serial overhead pin
   output logic             OVERHEAD_PORT_CLOCK_OUT,        // Port clock
   output logic             OVERHEAD_PORT_FRAME_STROBE_OUT, // Frame strobe
   output logic             OVERHEAD_PORT_WINDOW_N_OUT,     // Window, low active
   input  wire logic        S1_SLOT_IN,                     // S1 position pulse
   output logic      [7:0]  S1_BYTE_OUT,                    // Byte for S1 slot
   output logic             S1_STROBE_OUT                   // S1 byte valid pulse
);
   import tsbi_pkg::*;

   localparam int unsigned PW  = $clog2(PORT_DIV);
   localparam int unsigned FW  = $clog2(FRAME_PERIODS);
   localparam int unsigned LW  = $clog2(FIFO_DEPTH) + 1;
   localparam int unsigned SLW = ST_OVF_BIT - ST_LEVEL_LSB;
   localparam logic [PW-1:0] PH_RISE = PW'(PORT_DIV - 1);
   localparam logic [PW-1:0] PH_FALL = PW'(PORT_HALF - 1);
   localparam logic [FW-1:0] FR_LAST = FW'(FRAME_PERIODS - 1);

   if (FRAME_PERIODS <= S1_WAIT + S1_BITS + 2 || PORT_DIV < 2 || PORT_DIV % 2 != 0
       || LW > SLW)
   begin : g_bad_param
      $error("tsbi_top: frame too short, bad port divider or FIFO too deep");
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0]    tx_ctrl_q;
   logic [7:0]    s1_value_q;
   logic [7:0]    map_ctrl2_q;
   logic          ovf_q;
   logic          unf_q;
   logic [7:0]    last_cap_q;

   // ----------------------------------------------------------------
   // Port timing and serial input
   // ----------------------------------------------------------------
   logic          ser_meta_q;
   logic          ser_sync_q;
   logic [PW-1:0] phase_q;
   logic [FW-1:0] frame_cnt_q;
   logic          port_clk_q;
   logic          strobe_q;
   logic          window_n_q;
   logic [7:0]    s1_byte_q;
   logic          s1_stb_q;
   logic [31:0]   dat_out_q;
   logic          ack_q;

   tsbi_byte_t     cap_byte;
   logic           fifo_in_ready;
   logic           fifo_out_valid;
   logic [7:0]     fifo_out_data;
   logic [LW-1:0]  fifo_level;

   wire sw_mode   = tx_ctrl_q[SRC_SEL_BIT];
   wire ext_en    = map_ctrl2_q[EXT_OH_EN_BIT];
   wire ext_mode  = ext_en && !sw_mode;
   wire rise_tick = (phase_q == PH_RISE);
   wire fall_tick = (phase_q == PH_FALL);
   wire frame_end = fall_tick && (frame_cnt_q == FR_LAST);
   wire arm       = rise_tick && strobe_q;
   wire fifo_pop  = S1_SLOT_IN && !sw_mode;
   wire underrun  = fifo_pop && !fifo_out_valid;
   wire overflow  = cap_byte.valid && !fifo_in_ready;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire [13:0] idx      = WB_ADR_IN[15:2];
   wire        hit      = WB_CYC_IN && WB_STB_IN && !ack_q;
   wire        wr_lane0 = hit && WB_WE_IN && WB_SEL_IN[0];
   wire        wr_lane1 = hit && WB_WE_IN && WB_SEL_IN[1];
   wire        rd       = hit && !WB_WE_IN;
   wire        sel_ctrl = (idx == IDX_TX_CTRL);
   wire        sel_val  = (idx == IDX_S1_VALUE);
   wire        sel_map  = (idx == IDX_MAP_CTRL2);
   wire        sel_stat = (idx == IDX_STATUS);
   wire        clr_ovf  = wr_lane1 && sel_stat && WB_DAT_IN[ST_OVF_BIT];
   wire        clr_unf  = wr_lane1 && sel_stat && WB_DAT_IN[ST_UNF_BIT];

   wire [31:0] stat_word = {18'h00000, unf_q, ovf_q,
                            SLW'(fifo_level), last_cap_q};
   wire [31:0] rd_word   = sel_ctrl ? {24'h000000, tx_ctrl_q}   :
                           sel_val  ? {24'h000000, s1_value_q}  :
                           sel_map  ? {24'h000000, map_ctrl2_q} :
                           sel_stat ? stat_word                 :
                                      32'h00000000;

   assign WB_DAT_OUT                     = dat_out_q;
   assign WB_ACK_OUT                     = ack_q;
   assign OVERHEAD_PORT_CLOCK_OUT        = port_clk_q;
   assign OVERHEAD_PORT_FRAME_STROBE_OUT = strobe_q;
   assign OVERHEAD_PORT_WINDOW_N_OUT     = window_n_q;
   assign S1_BYTE_OUT                    = s1_byte_q;
   assign S1_STROBE_OUT                  = s1_stb_q;

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         tx_ctrl_q   <= TX_CTRL_RST;
         s1_value_q  <= S1_VALUE_RST;
         map_ctrl2_q <= MAP_CTRL2_RST;
      end
      else
      begin
         if (wr_lane0 && sel_ctrl)
            tx_ctrl_q <= WB_DAT_IN[7:0] & TX_CTRL_RW_MSK;
         if (wr_lane0 && sel_val)
            s1_value_q <= WB_DAT_IN[7:0];
         if (wr_lane0 && sel_map)
            map_ctrl2_q <= WB_DAT_IN[7:0];
      end
   end

   // Sticky flags, set wins over clear
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         ovf_q      <= 1'b0;
         unf_q      <= 1'b0;
         last_cap_q <= 8'h00;
      end
      else
      begin
         ovf_q <= overflow || (ovf_q && !clr_ovf);
         unf_q <= underrun || (unf_q && !clr_unf);
         if (cap_byte.valid)
            last_cap_q <= cap_byte.data;
      end
   end

   // Single-cycle answer, ack drops the cycle after
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         ack_q     <= 1'b0;
         dat_out_q <= 32'h00000000;
      end
      else
      begin
         ack_q     <= hit;
         dat_out_q <= rd ? rd_word : 32'h00000000;
      end
   end

   // ----------------------------------------------------------------
   // Port clock divider and frame strobe
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         ser_meta_q <= 1'b0;
         ser_sync_q <= 1'b0;
         phase_q    <= '0;
         port_clk_q <= 1'b0;
      end
      else
      begin
         ser_meta_q <= OVERHEAD_SERIAL_IN;
         ser_sync_q <= ser_meta_q;
         phase_q    <= rise_tick ? '0 : phase_q + 1'b1;
         if (rise_tick)
            port_clk_q <= 1'b1;
         else if (fall_tick)
            port_clk_q <= 1'b0;
      end
   end

   // Strobe spans one full port period around a rising edge
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         frame_cnt_q <= '0;
         strobe_q    <= 1'b0;
         window_n_q  <= 1'b1;
      end
      else if (fall_tick)
      begin
         frame_cnt_q <= frame_end ? '0 : frame_cnt_q + 1'b1;
         strobe_q    <= frame_end && ext_mode && fifo_in_ready;
         window_n_q  <= !(frame_end && ext_mode && fifo_in_ready);
      end
   end

   // ----------------------------------------------------------------
   // Capture, buffer and S1 slot fill
   // ----------------------------------------------------------------
   tsbi_capture #(
      .WAIT_PERIODS (S1_WAIT)
   ) u_capture (
      .clk_in   (CORE_CLK_IN),
      .rst_n_in (RESETN_IN),
      .rise_in  (rise_tick),
      .arm_in   (arm),
      .bit_in   (ser_sync_q),
      .byte_out (cap_byte)
   );

   tsbi_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (CORE_CLK_IN),
      .rst_n_in      (RESETN_IN),
      .in_valid_in   (cap_byte.valid),
      .in_data_in    (cap_byte.data),
      .in_ready_out  (fifo_in_ready),
      .out_valid_out (fifo_out_valid),
      .out_data_out  (fifo_out_data),
      .out_ready_in  (fifo_pop),
      .level_out     (fifo_level)
   );

   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         s1_byte_q <= 8'h00;
         s1_stb_q  <= 1'b0;
      end
      else
      begin
         s1_stb_q <= S1_SLOT_IN;
         if (S1_SLOT_IN && sw_mode)
            s1_byte_q <= s1_value_q;
         else if (fifo_pop && fifo_out_valid)
            s1_byte_q <= fifo_out_data;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_sw_insert: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      S1_SLOT_IN && sw_mode |=> S1_STROBE_OUT && S1_BYTE_OUT == $past(s1_value_q))
      else $error("software S1 value not placed in slot");

   a_value_write: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      wr_lane0 && sel_val |=> s1_value_q == $past(WB_DAT_IN[7:0]))
      else $error("S1 value register did not take write");

   a_value_read: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      rd && sel_val |=> WB_ACK_OUT && WB_DAT_OUT == {24'h000000, $past(s1_value_q)})
      else $error("S1 value readback wrong");

   a_window_gated: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      $rose(strobe_q) |-> $past(ext_mode) && !window_n_q)
      else $error("frame window opened without external overhead enable");

   a_strobe_width: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      $rose(strobe_q) |-> strobe_q[*8] ##1 (!strobe_q && window_n_q))
      else $error("frame strobe not one port period wide");

   a_port_insert: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      fifo_pop && fifo_out_valid |=> S1_STROBE_OUT && S1_BYTE_OUT == $past(fifo_out_data))
      else $error("port S1 byte not placed in slot");

endmodule
`default_nettype wire

// ### tsbi_pkg.sv
// Constants, register map and carrier types for the transmit S1 byte inserter.
// Assumes a 25 MHz core clock and a 32-bit classic Wishbone register bus.
package tsbi_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [13:0] IDX_TX_CTRL   = 14'h1902;
   localparam logic [13:0] IDX_S1_VALUE  = 14'h193B;
   localparam logic [13:0] IDX_MAP_CTRL2 = 14'h1A00;
   localparam logic [13:0] IDX_STATUS    = 14'h1A01;

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int unsigned SRC_SEL_BIT    = 2;
   localparam int unsigned EXT_OH_EN_BIT  = 4;
   localparam logic [7:0]  TX_CTRL_RW_MSK = 8'h3F;
   localparam logic [7:0]  TX_CTRL_RST    = 8'h00;
   localparam logic [7:0]  S1_VALUE_RST   = 8'h00;
   localparam logic [7:0]  MAP_CTRL2_RST  = 8'h00;
   localparam int unsigned ST_LEVEL_LSB   = 8;
   localparam int unsigned ST_OVF_BIT     = 12;
   localparam int unsigned ST_UNF_BIT     = 13;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CORE_PERIOD_NS = 40;
   localparam int unsigned PORT_PERIOD_NS = 320;
   localparam int unsigned PORT_DIV  = (PORT_PERIOD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
   localparam int unsigned PORT_HALF = PORT_DIV / 2;
   localparam int unsigned FRAME_PERIODS_DEF = 390;
   localparam int unsigned S1_WAIT_DEF       = 16;
   localparam int unsigned S1_BITS           = 8;
   localparam int unsigned FIFO_DEPTH_DEF    = 8;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } tsbi_byte_t;

endpackage

// ### tsbi_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock; DEPTH is a power of two.
`timescale 1ns/1ps
`default_nettype none
module tsbi_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = tsbi_pkg::FIFO_DEPTH_DEF
) (
   input  wire logic                     clk_in,       // Core clock
   input  wire logic                     rst_n_in,     // Async reset, low
   input  wire logic                     in_valid_in,  // Write request
   input  wire logic [WIDTH-1:0]         in_data_in,   // Write data
   output wire logic                     in_ready_out, // Not full
   output wire logic                     out_valid_out,// Not empty
   output wire logic [WIDTH-1:0]         out_data_out, // Head entry
   input  wire logic                     out_ready_in, // Pop request
   output wire logic [$clog2(DEPTH):0]   level_out     // Entries held
);
   import tsbi_pkg::*;
   localparam int unsigned AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin : g_bad_depth
      $error("tsbi_fifo: DEPTH must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      count_q;

   wire full  = (count_q == (AW+1)'(DEPTH));
   wire empty = (count_q == '0);
   wire push  = in_valid_in && !full;
   wire pop   = out_ready_in && !empty;

   assign in_ready_out  = !full;
   assign out_valid_out = !empty;
   assign out_data_out  = mem_q[rd_ptr_q];
   assign level_out     = count_q;

   for (genvar i = 0; i < DEPTH; i++)
   begin : g_entry
      always_ff @(posedge clk_in)
      begin
         if (push && wr_ptr_q == AW'(i))
            mem_q[i] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_q <= wr_ptr_q + 1'b1;
         if (pop)
            rd_ptr_q <= rd_ptr_q + 1'b1;
         if (push && !pop)
            count_q <= count_q + 1'b1;
         else if (pop && !push)
            count_q <= count_q - 1'b1;
      end
   end

endmodule
`default_nettype wire

// ### tsbi_capture.sv
// Serial S1 byte capture from the overhead input port.
// Assumes rise_in marks each port clock rising edge and bit_in is synchronised.
`timescale 1ns/1ps
`default_nettype none
module tsbi_capture #(
   parameter int unsigned WAIT_PERIODS = tsbi_pkg::S1_WAIT_DEF
) (
   input  wire logic               clk_in,   // Core clock
   input  wire logic               rst_n_in, // Async reset, low
   input  wire logic               rise_in,  // Port clock rising tick
   input  wire logic               arm_in,   // Frame strobe seen on this rise
   input  wire logic               bit_in,   // Synchronised serial bit
   output wire tsbi_pkg::tsbi_byte_t byte_out // Captured byte, valid pulse
);
   import tsbi_pkg::*;
   localparam int unsigned LAST = WAIT_PERIODS + S1_BITS;
   localparam int unsigned CW   = $clog2(LAST + 1);
   localparam int          CAP_DONE = LAST * PORT_DIV + 1;
   localparam int          MSB_AGE  = 1 + (S1_BITS - 1) * PORT_DIV;
   localparam int unsigned AGE_W    = $clog2(CAP_DONE + 1);
   localparam logic [AGE_W-1:0] AGE_TOP = AGE_W'(CAP_DONE);

   logic          active_q;
   logic [CW-1:0] cnt_q;
   logic [7:0]    shift_q;
   tsbi_byte_t    out_q;
   logic [AGE_W-1:0] age_q;

   wire [CW-1:0] cnt_inc   = cnt_q + 1'b1;
   wire          step      = active_q && rise_in && !arm_in;
   wire          bit_slot  = step && (cnt_inc > CW'(WAIT_PERIODS));
   wire          last_slot = step && (cnt_inc == CW'(LAST));
   wire [7:0]    shift_d   = {shift_q[6:0], bit_in};

   assign byte_out = out_q;

   // ----------------------------------------------------------------
   // Wait count, then MSB-first shift
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         active_q <= 1'b0;
         cnt_q    <= '0;
         shift_q  <= 8'h00;
         out_q    <= '0;
      end
      else
      begin
         if (arm_in)
         begin
            active_q <= 1'b1;
            cnt_q    <= '0;
         end
         else if (last_slot)
            active_q <= 1'b0;
         else if (step)
            cnt_q <= cnt_inc;
         if (bit_slot)
            shift_q <= shift_d;
         out_q.valid <= last_slot;
         if (last_slot)
            out_q.data <= shift_d;
      end
   end

   // Core cycles since arm, clears to zero the cycle after the capture deadline
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         age_q <= '0;
      else if (arm_in)
         age_q <= AGE_W'(1);
      else if (age_q != '0 && age_q != AGE_TOP)
         age_q <= age_q + 1'b1;
      else
         age_q <= '0;
   end

   a_capture_done: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      age_q == AGE_TOP |-> out_q.valid)
      else $error("byte not captured at expected rise after frame");

   a_capture_msb: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      out_q.valid |-> (out_q.data[0] == $past(bit_in)
                       && out_q.data[7] == $past(bit_in, MSB_AGE)))
      else $error("captured bits not latched on port clock rises");

endmodule
`default_nettype wire

// ### tsbi_far_end.sv
// Behavioural far-end logic that serialises one S1 byte per frame strobe.
// Assumes the device's port clock, frame strobe and window outputs.
`timescale 1ns/1ps
`default_nettype none
module tsbi_far_end #(
   parameter int unsigned WAIT = 2
) (
   input  wire logic rst_n_in,    // Async reset, low
   input  wire logic port_clk_in, // Port clock from device
   input  wire logic frame_in,    // Frame strobe
   input  wire logic window_n_in, // Window, low active
   output logic      serial_out   // Serial overhead bit
);
   int         cnt;
   logic [7:0] cur;
   logic [7:0] nxt;
   logic [7:0] sent_q[$];

   // ----------------------------------------------------------------
   // Strobe watch and wait count
   // ----------------------------------------------------------------
   always @(posedge port_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         cnt <= 0;
      else if (cnt == 0 && frame_in && !window_n_in)
      begin
         nxt = 8'($urandom);
         cur <= nxt;
         sent_q.push_back(nxt);
         cnt <= 1;
      end
      else if (cnt == WAIT + 9)
         cnt <= 0;
      else if (cnt != 0)
         cnt <= cnt + 1;
   end

   // ----------------------------------------------------------------
   // Bits launched on falls, MSB first; toggles when idle
   // ----------------------------------------------------------------
   always @(negedge port_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         serial_out <= 1'b0;
      else if (cnt > WAIT && cnt <= WAIT + 8)
         serial_out <= cur[WAIT + 8 - cnt];
      else
         serial_out <= ~serial_out;
   end
endmodule
`default_nettype wire

// ### test_tsbi_top.sv
// Self-checking bench for the transmit S1 byte inserter.
// Assumes tsbi_far_end as the serial partner and a 25 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
module test_tsbi_top;
   import tsbi_pkg::*;
   logic        clk, rst_n, cyc, stb, we, slot;
   logic [15:0] adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   logic [7:0]  v, last;
   wire  [31:0] dat_o;
   wire  [7:0]  s1_byte;
   wire         ack, ser, pclk, frm, win_n, s1_stb;
   int          err_total, comparisons;

   tsbi_top #(.FRAME_PERIODS(40), .S1_WAIT(2), .FIFO_DEPTH(8)) dut (
      .CORE_CLK_IN(clk), .RESETN_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
      .WB_DAT_OUT(dat_o), .WB_ACK_OUT(ack), .OVERHEAD_SERIAL_IN(ser),
      .OVERHEAD_PORT_CLOCK_OUT(pclk), .OVERHEAD_PORT_FRAME_STROBE_OUT(frm),
      .OVERHEAD_PORT_WINDOW_N_OUT(win_n), .S1_SLOT_IN(slot),
      .S1_BYTE_OUT(s1_byte), .S1_STROBE_OUT(s1_stb));

   tsbi_far_end #(.WAIT(2)) far (.rst_n_in(rst_n), .port_clk_in(pclk),
      .frame_in(frm), .window_n_in(win_n), .serial_out(ser));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Verdict, compares and bus tasks
   // ----------------------------------------------------------------
   task automatic print_verdict;
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_slot(input logic [8:0] e, input logic [8:0] g);
      comparisons++;
      if (g !== e)
      begin
         err_total++;
         $display("ERROR s1 slot expected %h seen %h", e, g);
      end
   endtask

   task automatic wb(input logic w, input logic [13:0] idx, input logic [31:0] d,
                     input logic [3:0] s);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; wdat <= d; sel <= s;
      @(posedge clk);
      while (ack !== 1'b1)
         @(posedge clk);
      rdat = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask

   task automatic rdchk(input string n, input logic [13:0] idx, input logic [31:0] e);
      wb(1'b0, idx, 32'h0, 4'hF);
      chk_reg(n, e, rdat);
   endtask

   task automatic slot_chk(input logic [7:0] e);
      @(posedge clk);
      slot <= 1'b1;
      @(posedge clk);
      slot <= 1'b0;
      @(posedge clk);
      chk_slot({1'b1, e}, {s1_stb, s1_byte});
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {cyc, stb, we, slot} = 4'h0;
      adr = 16'h0; sel = 4'h0; wdat = 32'h0; rst_n = 1'b0;
      err_total = 0; comparisons = 0;
      v = 8'($urandom(32'h6BEB));
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rdchk("ctrl reset", IDX_TX_CTRL, {24'h0, TX_CTRL_RST});
      rdchk("s1 reset", IDX_S1_VALUE, {24'h0, S1_VALUE_RST});
      rdchk("mapper reset", IDX_MAP_CTRL2, {24'h0, MAP_CTRL2_RST});
      rdchk("status reset", IDX_STATUS, 32'h0);
      wb(1'b1, IDX_TX_CTRL, 32'hFF, 4'h1);
      rdchk("ctrl mask", IDX_TX_CTRL, {24'h0, TX_CTRL_RW_MSK});
      wb(1'b1, 14'h0123, 32'h5A, 4'hF);
      rdchk("unmapped", 14'h0123, 32'h0);
      wb(1'b1, IDX_TX_CTRL, 32'h04, 4'h1);
      repeat (6)
      begin
         v = 8'($urandom);
         wb(1'b1, IDX_S1_VALUE, {24'h0, v}, 4'h1);
         rdchk("s1 value", IDX_S1_VALUE, {24'h0, v});
         slot_chk(v);
         slot_chk(v);
      end
      wb(1'b1, IDX_S1_VALUE, 32'hA5, 4'h2);
      rdchk("s1 lane", IDX_S1_VALUE, {24'h0, v});
      wb(1'b1, IDX_MAP_CTRL2, 32'h10, 4'h1);
      rdchk("mapper", IDX_MAP_CTRL2, 32'h10);
      wb(1'b1, IDX_TX_CTRL, 32'h00, 4'h1);
      repeat (12 * 40 * PORT_DIV) @(posedge clk);
      chk_reg("bytes sent", 32'h8, 32'(far.sent_q.size()));
      last = far.sent_q[$];
      rdchk("status full", IDX_STATUS, (32'h8 << ST_LEVEL_LSB) | last);
      wb(1'b1, IDX_MAP_CTRL2, 32'h00, 4'h1);
      repeat (8) slot_chk(far.sent_q.pop_front());
      slot_chk(last);
      rdchk("status underrun", IDX_STATUS, (32'h1 << ST_UNF_BIT) | last);
      wb(1'b1, IDX_STATUS, 32'h1 << ST_UNF_BIT, 4'h2);
      rdchk("status clear", IDX_STATUS, {24'h0, last});
      wb(1'b1, IDX_TX_CTRL, 32'h04, 4'h1);
      slot_chk(v);
      print_verdict;
   end

   initial
   begin
      repeat (12000) @(posedge clk);
      err_total++;
      print_verdict;
   end
endmodule
`default_nettype wire
